// ==== dps_pkg.sv ====
// Shared constants for the debug pin speed probe and breakpoint.
// Assumes one clock, CLK_IN at 40 MHz, standing in for the target debug clock.
// Contract
// - Host holds pin low at least 128 slow cycles.
// - Slowest debug clock is reference divided by 64.
// - Host drives brief high speedup pulse after low.
// - Host releases pin, then watches for answer.
// - Target detects long low, waits for high.
// - Target waits 16 cycles before driving.
// - Target drives pin low exactly 128 cycles.
// - Target drives high one cycle, then releases.
// - Host times answer low width for bit rate.
// - One breakpoint compares bus address with 16-bit match.
// - Forced mode: any access halts at instruction boundary.
// - Tagged mode: tagged opcode halts at queue end.
// - Enable resets to 0; disabled raises nothing. Here enable is the BKPT_EN_IN input, which the target does not reset.
// - Select 1 means forced, 0 means tagged.
package dps_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned PROBE_LOW_CYCLES = 128;
    localparam int unsigned SLOW_DIV = 64;
    localparam int unsigned TARGET_DELAY_CYCLES = 16;
    localparam int unsigned ANSWER_LOW_CYCLES = 128;
    localparam int unsigned SPEEDUP_CYCLES = 1;
    // Far longer than any low in normal traffic, yet shorter than the host probe.
    localparam int unsigned DETECT_LOW_CYCLES = 64;
    // Bound on the host's wait for an answer, so a silent target cannot hang it.
    localparam int unsigned HOST_TIMEOUT_CYCLES = 4000;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned CNT_W = 16;
    localparam logic BKPT_EN_RESET = 1'b0;
    localparam logic FTS_FORCED = 1'b1;
    localparam logic [15:0] MATCH_RESET = 16'h0000;
endpackage

// ==== dps_link_if.sv ====
// Debug pin wire between target and host.
// Assumes a pull-up: the wire reads high when neither end drives it.
`timescale 1ns/1ps
`default_nettype none
interface dps_link_if;
    logic tgt_out;
    logic tgt_oe;
    logic host_out;
    logic host_oe;
    logic pin;
    assign pin = (tgt_oe && !tgt_out) || (host_oe && !host_out) ? 1'b0 : 1'b1;
    modport target (input pin, output tgt_out, output tgt_oe);
    modport host (input pin, output host_out, output host_oe);
endinterface
`default_nettype wire

// ==== dps_target.sv ====
// Target end: speed-probe responder and address-match breakpoint.
// Assumes CPU bus signals synchronous to CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module dps_target #(
    parameter int unsigned DETECT_CYCLES = dps_pkg::DETECT_LOW_CYCLES,
    parameter int unsigned DELAY_CYCLES = dps_pkg::TARGET_DELAY_CYCLES,
    parameter int unsigned LOW_CYCLES = dps_pkg::ANSWER_LOW_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    dps_link_if.target LINK,
    input wire logic BKPT_EN_IN,
    input wire logic FORCE_TAG_IN,
    input wire logic [dps_pkg::ADDR_W-1:0] MATCH_IN,
    input wire logic [dps_pkg::ADDR_W-1:0] BUS_ADDR_IN,
    input wire logic BUS_ACCESS_IN,
    input wire logic OPCODE_FETCH_IN,
    input wire logic INSTR_BOUNDARY_IN,
    input wire logic QUEUE_END_IN,
    output logic PROBE_BUSY_OUT,
    output logic ENTER_BGND_OUT
);
    import dps_pkg::*;
    typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_WAIT_HIGH, ST_DELAY, ST_DRIVE_LOW,
        ST_SPEEDUP} dps_tstate_t;
    typedef struct packed {
        dps_tstate_t st;
        logic [CNT_W-1:0] cnt;
        logic out;
        logic oe;
        logic forced_pend;
        logic tag_pend;
        logic bgnd;
    } dps_treg_t;
    dps_treg_t r_ff, nxt_r;
    logic hit;

    always_comb begin
        hit = BKPT_EN_IN && (BUS_ADDR_IN == MATCH_IN);
        nxt_r = r_ff;
        nxt_r.bgnd = 1'b0;
        case (r_ff.st)
            ST_IDLE: begin
                nxt_r.oe = 1'b0;
                nxt_r.cnt = '0;
                if (!LINK.pin) begin
                    nxt_r.st = ST_LOW;
                end
            end
            ST_LOW: begin
                if (LINK.pin) begin
                    nxt_r.st = ST_IDLE;
                end else if (r_ff.cnt >= CNT_W'(DETECT_CYCLES - 1)) begin
                    nxt_r.st = ST_WAIT_HIGH;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            ST_WAIT_HIGH: begin
                nxt_r.cnt = '0;
                if (LINK.pin) begin
                    nxt_r.st = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (r_ff.cnt == CNT_W'(DELAY_CYCLES - 1)) begin
                    nxt_r.st = ST_DRIVE_LOW;
                    nxt_r.cnt = '0;
                    nxt_r.oe = 1'b1;
                    nxt_r.out = 1'b0;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            ST_DRIVE_LOW: begin
                if (r_ff.cnt == CNT_W'(LOW_CYCLES - 1)) begin
                    nxt_r.st = ST_SPEEDUP;
                    nxt_r.out = 1'b1;
                    nxt_r.cnt = '0;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            ST_SPEEDUP: begin
                nxt_r.st = ST_IDLE;
                nxt_r.oe = 1'b0;
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
        // Pending requests are held so a hit between boundaries is not lost.
        if (!BKPT_EN_IN) begin
            nxt_r.forced_pend = 1'b0;
            nxt_r.tag_pend = 1'b0;
        end else begin
            if (FORCE_TAG_IN == FTS_FORCED) begin
                if (r_ff.forced_pend && INSTR_BOUNDARY_IN) begin
                    nxt_r.forced_pend = 1'b0;
                    nxt_r.bgnd = 1'b1;
                end
                if (hit && BUS_ACCESS_IN) begin
                    nxt_r.forced_pend = 1'b1;
                end
            end else begin
                if (r_ff.tag_pend && QUEUE_END_IN) begin
                    nxt_r.tag_pend = 1'b0;
                    nxt_r.bgnd = 1'b1;
                end
                if (hit && OPCODE_FETCH_IN) begin
                    nxt_r.tag_pend = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r_ff <= '{st: ST_IDLE, cnt: '0, out: 1'b1, oe: 1'b0, forced_pend: 1'b0,
                tag_pend: 1'b0, bgnd: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign LINK.tgt_out = r_ff.out;
    assign LINK.tgt_oe = r_ff.oe;
    assign PROBE_BUSY_OUT = (r_ff.st != ST_IDLE);
    assign ENTER_BGND_OUT = r_ff.bgnd;
endmodule
`default_nettype wire

// ==== dps_host.sv ====
// Host end: issues a speed probe and measures the answering low width.
// Assumes the target shares CLK_IN; probe length is a parameter.
`timescale 1ns/1ps
`default_nettype none
module dps_host #(
    parameter int unsigned PROBE_CYCLES = dps_pkg::PROBE_LOW_CYCLES * dps_pkg::SLOW_DIV,
    parameter int unsigned TIMEOUT_CYCLES = dps_pkg::HOST_TIMEOUT_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    dps_link_if.host LINK,
    input wire logic START_IN,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic [dps_pkg::CNT_W-1:0] WIDTH_OUT
);
    import dps_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_SPEEDUP, H_WAIT, H_MEASURE} dps_hstate_t;
    typedef struct packed {
        dps_hstate_t st;
        logic [CNT_W-1:0] cnt;
        logic out;
        logic oe;
        logic done;
        logic [CNT_W-1:0] width;
    } dps_hreg_t;
    dps_hreg_t r_ff, nxt_r;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        case (r_ff.st)
            H_IDLE: begin
                nxt_r.cnt = '0;
                if (START_IN) begin
                    nxt_r.st = H_LOW;
                    nxt_r.oe = 1'b1;
                    nxt_r.out = 1'b0;
                end
            end
            H_LOW: begin
                if (r_ff.cnt == CNT_W'(PROBE_CYCLES - 1)) begin
                    nxt_r.st = H_SPEEDUP;
                    nxt_r.out = 1'b1;
                    nxt_r.cnt = '0;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            H_SPEEDUP: begin
                nxt_r.st = H_WAIT;
                nxt_r.oe = 1'b0;
            end
            H_WAIT: begin
                if (!LINK.pin) begin
                    nxt_r.st = H_MEASURE;
                    nxt_r.cnt = 16'h0001;
                end else if (r_ff.cnt == CNT_W'(TIMEOUT_CYCLES - 1)) begin
                    nxt_r.st = H_IDLE;
                    nxt_r.width = '0;
                    nxt_r.done = 1'b1;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            H_MEASURE: begin
                if (LINK.pin) begin
                    nxt_r.st = H_IDLE;
                    nxt_r.width = r_ff.cnt;
                    nxt_r.done = 1'b1;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            default: begin
                nxt_r.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r_ff <= '{st: H_IDLE, cnt: '0, out: 1'b1, oe: 1'b0, done: 1'b0, width: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign LINK.host_out = r_ff.out;
    assign LINK.host_oe = r_ff.oe;
    assign BUSY_OUT = (r_ff.st != H_IDLE);
    assign DONE_OUT = r_ff.done;
    assign WIDTH_OUT = r_ff.width;
endmodule
`default_nettype wire

// ==== dps_props.sv ====
// Wire checker for the speed-probe answer on the host-to-target link.
// Assumes one shared clock and a pulled-up debug pin.
`timescale 1ns/1ps
`default_nettype none
module dps_props #(
    parameter int unsigned DETECT_CYCLES = dps_pkg::DETECT_LOW_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic tgt_out,
    input wire logic tgt_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic pin
);
    logic tlow;
    logic hlow;
    logic [15:0] tcnt_ff, hcnt_ff, lcnt_ff;
    logic seen_ff;
    assign tlow = tgt_oe && !tgt_out;
    assign hlow = host_oe && !host_out;
    // The flag remembers a long host low so an answer is only legal after one.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tcnt_ff <= 16'h0000;
            hcnt_ff <= 16'h0000;
            lcnt_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else begin
            tcnt_ff <= tlow ? tcnt_ff + 16'h0001 : 16'h0000;
            hcnt_ff <= pin ? hcnt_ff + 16'h0001 : 16'h0000;
            lcnt_ff <= (host_oe && !host_out) ? lcnt_ff + 16'h0001 : 16'h0000;
            if (host_oe && !host_out && lcnt_ff >= 16'(DETECT_CYCLES - 1)) begin
                seen_ff <= 1'b1;
            end else if (tlow) begin
                seen_ff <= 1'b0;
            end
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence s_tail;
        tgt_oe && tgt_out ##1 !tgt_oe;
    endsequence
    sequence s_host_tail;
        host_oe && host_out ##1 !host_oe;
    endsequence
    AST_HOST_LOW: assert property ($fell(hlow) |-> lcnt_ff >= 16'h0080)
        else $error("host probe low shorter than 128 cycles");
    AST_HOST_SPEEDUP: assert property ($fell(hlow) |-> s_host_tail)
        else $error("host probe low not followed by one high cycle and release");
    AST_LOW_WIDTH: assert property ($fell(tlow) |-> tcnt_ff == 16'h0080)
        else $error("answer low width is not 128 cycles");
    AST_LOW_MAX: assert property (tcnt_ff <= 16'h0080)
        else $error("answer low runs past 128 cycles");
    AST_TAIL: assert property ($fell(tlow) |-> s_tail)
        else $error("answer not followed by one high cycle and release");
    AST_TAIL_ONE: assert property (tgt_oe && tgt_out |=> !tgt_oe)
        else $error("target high drive lasts more than one cycle");
    AST_DELAY: assert property ($rose(tlow) |-> hcnt_ff >= 16'h0010 && hcnt_ff <= 16'h0011)
        else $error("answer started without the 16 cycle delay");
    AST_NEEDS_PROBE: assert property ($rose(tlow) |-> seen_ff)
        else $error("target answered without a long low");
    AST_IDLE: assert property ($fell(tgt_oe) |=> (!tgt_oe) [*8])
        else $error("target drives again right after release");
    AST_NO_CLASH: assert property (tlow |-> !host_oe)
        else $error("host drives while target answers");
endmodule
`default_nettype wire

// ==== dps_bench.sv ====
// Bench: host and target on one link, a lone target driven by the bench on a second.
// Assumes the design files and dps_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dps_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic en, force_tag_select, acc, fch, bnd, qe, bg, done;
    logic busy_h, busy_t, busy_t2, bg2;
    logic [15:0] mt, ad, width;
    int err_count = 0;
    int compares = 0;
    dps_link_if link_i ();
    dps_link_if link2_i ();
    always #12.5 clk = ~clk;
    dps_host #(.PROBE_CYCLES(128), .TIMEOUT_CYCLES(300)) dps_host_i (.CLK_IN(clk),
        .RST_N_IN(rst_n), .LINK(link_i), .START_IN(start), .BUSY_OUT(busy_h), .DONE_OUT(done),
        .WIDTH_OUT(width));
    dps_target dps_target_i (.CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link_i), .BKPT_EN_IN(en),
        .FORCE_TAG_IN(force_tag_select), .MATCH_IN(mt), .BUS_ADDR_IN(ad), .BUS_ACCESS_IN(acc),
        .OPCODE_FETCH_IN(fch), .INSTR_BOUNDARY_IN(bnd), .QUEUE_END_IN(qe),
        .PROBE_BUSY_OUT(busy_t), .ENTER_BGND_OUT(bg));
    dps_target dps_target_i2 (.CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link2_i), .BKPT_EN_IN(en),
        .FORCE_TAG_IN(force_tag_select), .MATCH_IN(mt), .BUS_ADDR_IN(ad), .BUS_ACCESS_IN(acc),
        .OPCODE_FETCH_IN(fch), .INSTR_BOUNDARY_IN(bnd), .QUEUE_END_IN(qe),
        .PROBE_BUSY_OUT(busy_t2), .ENTER_BGND_OUT(bg2));
    dps_props #(.DETECT_CYCLES(64)) dps_props_i (.CLK_IN(clk), .RST_N_IN(rst_n),
        .tgt_out(link_i.tgt_out), .tgt_oe(link_i.tgt_oe), .host_out(link_i.host_out),
        .host_oe(link_i.host_oe), .pin(link_i.pin));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task complete_run;
        $display("Checks %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task probe;
        int n;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        chk("host busy", 16'h0001, 16'(busy_h));
        // A second start while the probe runs must be ignored.
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("width", 16'(dps_pkg::ANSWER_LOW_CYCLES), width);
        chk("host busy", 16'h0000, 16'(busy_h));
        chk("target busy", 16'h0000, 16'(busy_t));
    endtask
    // The bench stands in for the host here, so short lows can be sent on purpose.
    task probe2(input int len, input logic ans);
        int n;
        int w;
        @(posedge clk);
        link2_i.host_oe <= 1'b1;
        link2_i.host_out <= 1'b0;
        repeat (len) @(posedge clk);
        link2_i.host_out <= 1'b1;
        @(posedge clk);
        link2_i.host_oe <= 1'b0;
        n = 0;
        while (link2_i.pin !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("answer", 16'(ans), 16'(!link2_i.pin));
        chk("probe busy", 16'(ans), 16'(busy_t2));
        if (ans) begin
            chk("delay", 16'(dps_pkg::TARGET_DELAY_CYCLES + 1), 16'(n));
            w = 0;
            while (link2_i.pin === 1'b0 && w < 300) begin
                @(negedge clk);
                w++;
            end
            chk("low", 16'(dps_pkg::ANSWER_LOW_CYCLES), 16'(w));
            chk("tail", 16'h0001, 16'(link2_i.tgt_oe & link2_i.tgt_out));
            @(negedge clk);
            chk("release", 16'h0000, 16'(link2_i.tgt_oe));
            chk("idle busy", 16'h0000, 16'(busy_t2));
        end
    endtask
    function automatic logic exp_bgnd(input logic e, input logic f, input logic a,
        input logic c, input logic b, input logic q, input logic [15:0] m,
        input logic [15:0] d);
        return e && d == m && (f ? a && b : c && q);
    endfunction
    task bp(input int i);
        logic [15:0] m, d;
        logic e, f, a, c, b, q;
        logic x;
        m = i < 2 ? 16'hFFFF : 16'($urandom);
        d = (i < 2 || 1'($urandom)) ? m : m ^ (16'h0001 << ($urandom % 16));
        e = i == 0 || (i > 1 && $urandom % 4 != 0);
        f = i == 0 || 1'($urandom);
        a = i < 2 || 1'($urandom);
        c = 1'($urandom);
        b = i < 2 || 1'($urandom);
        q = 1'($urandom);
        x = exp_bgnd(e, f, a, c, b, q, m, d);
        @(posedge clk);
        {en, force_tag_select, mt, ad, acc, fch} <= {e, f, m, d, a, c};
        @(posedge clk);
        {acc, fch, bnd, qe} <= {1'b0, 1'b0, b, q};
        @(posedge clk);
        {bnd, qe, en} <= 3'h0;
        @(negedge clk);
        chk("bgnd", 16'(x), 16'(bg));
        chk("bgnd2", 16'(x), 16'(bg2));
    endtask
    initial begin
        void'($urandom(14099));
        {en, force_tag_select, acc, fch, bnd, qe} = 6'h00;
        mt = 16'h0000;
        ad = 16'h0000;
        link2_i.host_oe = 1'b0;
        link2_i.host_out = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        probe();
        probe();
        probe2(8 + $urandom % 48, 1'b0);
        probe2(70 + $urandom % 30, 1'b1);
        for (int i = 0; i < 40; i++) begin
            bp(i);
        end
        complete_run();
    end
    initial begin
        #(25 * 5000);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
